// [rtl/bwcfg_pkg.sv]
`default_nettype none

package bwcfg_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_START = 10'h024;
  localparam logic [9:0] IDX_END = 10'h026;
  localparam logic [9:0] IDX_START_HIGH = 10'h028;
  localparam logic [9:0] IDX_END_HIGH = 10'h02c;
  localparam logic [9:0] IDX_IO_START_HIGH = 10'h030;
  localparam logic [9:0] IDX_IO_END_HIGH = 10'h032;
  localparam logic [9:0] IDX_CAP_HEAD = 10'h034;
  localparam logic [9:0] IDX_OPTION_ROM = 10'h038;
  localparam logic [9:0] IDX_IRQ_ROUTING = 10'h03c;
  localparam logic [9:0] IDX_WRITE_LOCK = 10'h040;
  localparam logic [9:0] IDX_STATUS = 10'h041;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CAP_BIT = 0;
  localparam int WIN_LSB = 4;
  localparam int WIN_MSB = 15;
  localparam int LOCK_OPEN_BIT = 0;
  localparam int STAT_HIT_BIT = 0;
  localparam int STAT_CAP_BIT = 1;
  localparam int STAT_IO_WIDTH_CAPABILITY_BIT = 2;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic RST_CAP = 1'h1;
  localparam logic [11:0] RST_START = 12'hfff;
  localparam logic [11:0] RST_END = 12'h000;
  localparam logic [31:0] RST_START_HIGH = 32'hffffffff;
  localparam logic [31:0] RST_END_HIGH = 32'h00000000;
  localparam logic [15:0] RST_IO_START_HIGH = 16'hffff;
  localparam logic [15:0] RST_IO_END_HIGH = 16'h0000;
  localparam logic [7:0] RST_CAP_HEAD = 8'h40;
  localparam logic [7:0] RST_IRQ_ROUTING = 8'h00;
  localparam logic RST_LOCK_OPEN = 1'h0;

  // ----------------------------------------------------------------
  // Window composition and bus codes
  // ----------------------------------------------------------------
  localparam logic [19:0] WIN_LOW_ZERO = 20'h00000;
  localparam logic [19:0] WIN_LOW_ONES = 20'hfffff;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage

`default_nettype wire

// [rtl/bwcfg_window_match.sv]
`timescale 1ns/1ns
`default_nettype none

module bwcfg_window_match (
  // Address under test
  input wire logic [63:0] addr,
  // Window registers
  input wire logic prefetch_width_capability,
  input wire logic [11:0] start_field,
  input wire logic [11:0] end_field,
  input wire logic [31:0] start_high,
  input wire logic [31:0] end_high,
  // Result
  output logic in_window
);

  // ----------------------------------------------------------------
  // Composed bounds
  // ----------------------------------------------------------------
  wire logic [31:0] eff_start_high;
  wire logic [31:0] eff_end_high;
  wire logic [63:0] base;
  wire logic [63:0] limit;

  assign eff_start_high = prefetch_width_capability ? start_high : 32'h00000000;
  assign eff_end_high = prefetch_width_capability ? end_high : 32'h00000000;
  assign base = {eff_start_high, start_field, bwcfg_pkg::WIN_LOW_ZERO};
  assign limit = {eff_end_high, end_field, bwcfg_pkg::WIN_LOW_ONES};
  // Base above limit gives an empty window, as software expects
  assign in_window = (addr >= base) && (addr <= limit);

endmodule

`default_nettype wire

// [rtl/bwcfg_regs.sv]
`timescale 1ns/1ns
`default_nettype none

module bwcfg_regs (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // I/O width capability from the I/O base register
  input wire logic io_width_capability,
  // Forwarding lookup
  input wire logic txn_valid,
  input wire logic [63:0] txn_addr,
  output logic pref_hit_valid,
  output logic pref_hit,
  // I/O window high halves for the forwarding logic
  output logic [15:0] io_start_high,
  output logic [15:0] io_end_high
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic prefetch_width_capability;
  logic [11:0] start_field;
  logic [11:0] end_field;
  logic [31:0] start_high;
  logic [31:0] end_high;
  logic [15:0] io_start_high_store;
  logic [15:0] io_end_high_store;
  logic [7:0] capability_list_head;
  logic [7:0] irq_routing_byte;
  logic lock_open;
  logic last_hit;

  // Bus pipeline state
  logic wr_pend;
  logic rd_pend;
  logic rd_done;
  logic [9:0] wr_idx;
  logic [9:0] rd_idx;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic hits(input logic [9:0] idx, input logic [9:0] target);
    hits = (idx == target);
  endfunction

  wire logic accept;
  wire logic [9:0] addr_idx;
  wire logic we_start;
  wire logic we_end;
  wire logic we_start_high;
  wire logic we_end_high;
  wire logic we_io_start_high;
  wire logic we_io_end_high;
  wire logic we_cap_head;
  wire logic we_irq;
  wire logic we_lock;

  assign accept = hsel && htrans[1] && hready;
  // Upper address bits are not decoded, so the map aliases every 4 KB
  assign addr_idx = haddr[11:2];
  assign we_start = wr_pend && hits(wr_idx, bwcfg_pkg::IDX_START);
  assign we_end = wr_pend && hits(wr_idx, bwcfg_pkg::IDX_END);
  assign we_start_high = wr_pend && hits(wr_idx, bwcfg_pkg::IDX_START_HIGH);
  assign we_end_high = wr_pend && hits(wr_idx, bwcfg_pkg::IDX_END_HIGH);
  assign we_io_start_high = wr_pend && hits(wr_idx, bwcfg_pkg::IDX_IO_START_HIGH);
  assign we_io_end_high = wr_pend && hits(wr_idx, bwcfg_pkg::IDX_IO_END_HIGH);
  assign we_cap_head = wr_pend && hits(wr_idx, bwcfg_pkg::IDX_CAP_HEAD);
  assign we_irq = wr_pend && hits(wr_idx, bwcfg_pkg::IDX_IRQ_ROUTING);
  assign we_lock = wr_pend && hits(wr_idx, bwcfg_pkg::IDX_WRITE_LOCK);

  // ----------------------------------------------------------------
  // Effective values and read selection
  // ----------------------------------------------------------------
  wire logic [31:0] eff_start_high;
  wire logic [31:0] eff_end_high;
  wire logic [15:0] eff_io_start_high;
  wire logic [15:0] eff_io_end_high;
  wire logic [31:0] rd_start;
  wire logic [31:0] rd_end;
  wire logic [31:0] rd_status;
  wire logic [31:0] rd_value;

  assign eff_start_high = prefetch_width_capability ? start_high : 32'h00000000;
  assign eff_end_high = prefetch_width_capability ? end_high : 32'h00000000;
  assign eff_io_start_high = io_width_capability ? io_start_high_store : 16'h0000;
  assign eff_io_end_high = io_width_capability ? io_end_high_store : 16'h0000;
  assign rd_start = {16'h0000, start_field, 3'h0, prefetch_width_capability};
  assign rd_end = {16'h0000, end_field, 3'h0, prefetch_width_capability};
  assign rd_status = {29'h00000000, io_width_capability, prefetch_width_capability, last_hit};

  assign rd_value =
    hits(rd_idx, bwcfg_pkg::IDX_START) ? rd_start :
    hits(rd_idx, bwcfg_pkg::IDX_END) ? rd_end :
    hits(rd_idx, bwcfg_pkg::IDX_START_HIGH) ? eff_start_high :
    hits(rd_idx, bwcfg_pkg::IDX_END_HIGH) ? eff_end_high :
    hits(rd_idx, bwcfg_pkg::IDX_IO_START_HIGH) ? {16'h0000, eff_io_start_high} :
    hits(rd_idx, bwcfg_pkg::IDX_IO_END_HIGH) ? {16'h0000, eff_io_end_high} :
    hits(rd_idx, bwcfg_pkg::IDX_CAP_HEAD) ? {24'h000000, capability_list_head} :
    hits(rd_idx, bwcfg_pkg::IDX_IRQ_ROUTING) ? {24'h000000, irq_routing_byte} :
    hits(rd_idx, bwcfg_pkg::IDX_WRITE_LOCK) ? {31'h00000000, lock_open} :
    hits(rd_idx, bwcfg_pkg::IDX_STATUS) ? rd_status :
    32'h00000000;

  // ----------------------------------------------------------------
  // AHB-Lite pipeline
  // ----------------------------------------------------------------
  // Reads take one wait state so a write just before them is visible
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      rd_done <= 1'b0;
      wr_idx <= 10'h000;
      rd_idx <= 10'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      wr_pend <= accept && hwrite && (hsize == bwcfg_pkg::HSIZE_WORD);
      rd_pend <= accept && !hwrite;
      rd_done <= rd_pend;
      if (accept) begin
        wr_idx <= addr_idx;
        rd_idx <= addr_idx;
      end
      hreadyout <= !(accept && !hwrite);
      hresp <= 1'b0;
      if (rd_pend) begin
        hrdata <= rd_value;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      prefetch_width_capability <= bwcfg_pkg::RST_CAP;
      start_field <= bwcfg_pkg::RST_START;
      end_field <= bwcfg_pkg::RST_END;
      start_high <= bwcfg_pkg::RST_START_HIGH;
      end_high <= bwcfg_pkg::RST_END_HIGH;
      io_start_high_store <= bwcfg_pkg::RST_IO_START_HIGH;
      io_end_high_store <= bwcfg_pkg::RST_IO_END_HIGH;
      capability_list_head <= bwcfg_pkg::RST_CAP_HEAD;
      irq_routing_byte <= bwcfg_pkg::RST_IRQ_ROUTING;
      lock_open <= bwcfg_pkg::RST_LOCK_OPEN;
    end else begin
      if (we_start) begin
        start_field <= hwdata[bwcfg_pkg::WIN_MSB:bwcfg_pkg::WIN_LSB];
        if (lock_open) begin
          prefetch_width_capability <= hwdata[bwcfg_pkg::CAP_BIT];
        end
      end
      if (we_end) begin
        end_field <= hwdata[bwcfg_pkg::WIN_MSB:bwcfg_pkg::WIN_LSB];
      end
      if (we_start_high && prefetch_width_capability) begin
        start_high <= hwdata;
      end
      if (we_end_high && prefetch_width_capability) begin
        end_high <= hwdata;
      end
      if (we_io_start_high && io_width_capability) begin
        io_start_high_store <= hwdata[15:0];
      end
      if (we_io_end_high && io_width_capability) begin
        io_end_high_store <= hwdata[15:0];
      end
      if (we_cap_head && lock_open) begin
        capability_list_head <= hwdata[7:0];
      end
      if (we_irq) begin
        irq_routing_byte <= hwdata[7:0];
      end
      if (we_lock) begin
        lock_open <= hwdata[bwcfg_pkg::LOCK_OPEN_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Forwarding lookup
  // ----------------------------------------------------------------
  wire logic in_window;

  bwcfg_window_match u_match (
    .addr(txn_addr),
    .prefetch_width_capability(prefetch_width_capability),
    .start_field(start_field),
    .end_field(end_field),
    .start_high(start_high),
    .end_high(end_high),
    .in_window(in_window)
  );

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pref_hit_valid <= 1'b0;
      pref_hit <= 1'b0;
      last_hit <= 1'b0;
      io_start_high <= 16'h0000;
      io_end_high <= 16'h0000;
    end else begin
      pref_hit_valid <= txn_valid;
      pref_hit <= txn_valid && in_window;
      if (txn_valid) begin
        last_hit <= in_window;
      end
      io_start_high <= eff_io_start_high;
      io_end_high <= eff_io_end_high;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  wire logic [63:0] chk_base;
  wire logic [63:0] chk_limit;

  assign chk_base = {eff_start_high, start_field, bwcfg_pkg::WIN_LOW_ZERO};
  assign chk_limit = {eff_end_high, end_field, bwcfg_pkg::WIN_LOW_ONES};

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  property p_cap_reset;
    $fell(srst) |-> prefetch_width_capability && (start_field == 12'hfff);
  endproperty
  a_cap_reset: assert property (p_cap_reset) else $error("capability or start bad after reset");

  property p_high_reset;
    $fell(srst) |-> (start_high == 32'hffffffff) && (end_high == 32'h00000000)
      && (end_field == 12'h000);
  endproperty
  a_high_reset: assert property (p_high_reset) else $error("window reset values bad");

  property p_misc_reset;
    $fell(srst) |-> (capability_list_head == 8'h40) && (irq_routing_byte == 8'h00)
      && (io_start_high_store == 16'hffff) && (io_end_high_store == 16'h0000);
  endproperty
  a_misc_reset: assert property (p_misc_reset) else $error("misc reset values bad");

  property p_cap_locked;
    (we_start && !lock_open) |=> $stable(prefetch_width_capability);
  endproperty
  a_cap_locked: assert property (p_cap_locked) else $error("capability changed while locked");

  property p_end_readback;
    (rd_done && hits(rd_idx, bwcfg_pkg::IDX_END))
      |-> (hrdata[0] == prefetch_width_capability) && (hrdata[3:1] == 3'h0) && hreadyout;
  endproperty
  a_end_readback: assert property (p_end_readback) else $error("end bit 0 mismatch");

  property p_high_zero;
    (rd_done && !prefetch_width_capability && (hits(rd_idx, bwcfg_pkg::IDX_START_HIGH)
      || hits(rd_idx, bwcfg_pkg::IDX_END_HIGH))) |-> (hrdata == 32'h00000000);
  endproperty
  a_high_zero: assert property (p_high_zero) else $error("high word not zero");

  property p_high_ignored;
    ((we_start_high || we_end_high) && !prefetch_width_capability)
      |=> $stable(start_high) && $stable(end_high);
  endproperty
  a_high_ignored: assert property (p_high_ignored) else $error("high word written");

  property p_io_zero;
    (rd_done && !$past(io_width_capability) && (hits(rd_idx, bwcfg_pkg::IDX_IO_START_HIGH)
      || hits(rd_idx, bwcfg_pkg::IDX_IO_END_HIGH))) |-> (hrdata == 32'h00000000);
  endproperty
  a_io_zero: assert property (p_io_zero) else $error("io high not zero");

  property p_rom_zero;
    (rd_done && hits(rd_idx, bwcfg_pkg::IDX_OPTION_ROM)) |-> (hrdata == 32'h00000000);
  endproperty
  a_rom_zero: assert property (p_rom_zero) else $error("option rom not zero");

  property p_irq_store;
    we_irq |=> (irq_routing_byte == $past(hwdata[7:0]));
  endproperty
  a_irq_store: assert property (p_irq_store) else $error("irq byte not stored");

  property p_hit;
    txn_valid |=> pref_hit_valid
      && (pref_hit == (($past(txn_addr) >= $past(chk_base)) && ($past(txn_addr) <= $past(chk_limit))));
  endproperty
  a_hit: assert property (p_hit) else $error("window decision wrong");

  property p_read_wait;
    (accept && !hwrite) |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");

  c_hit: cover property (txn_valid ##1 pref_hit);
  c_narrow: cover property (we_start && lock_open && !hwdata[0]);
  c_high_read: cover property (rd_done && hits(rd_idx, bwcfg_pkg::IDX_START_HIGH));
  c_irq: cover property (we_irq);

endmodule

`default_nettype wire

// [verif/bwcfg_testbench.sv]
`timescale 1ns/1ns
`default_nettype none

module testbench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic sys_clk;
  logic srst;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic io_width_capability;
  logic txn_valid;
  logic [63:0] txn_addr;
  logic pref_hit_valid;
  logic pref_hit;
  logic [15:0] io_start_high;
  logic [15:0] io_end_high;
  wire logic hready;
  int mismatches;
  int n_checks;

  // Single slave: its ready is the bus ready
  assign hready = hreadyout;

  bwcfg_regs u_bwcfg_regs (
    .sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .io_width_capability(io_width_capability), .txn_valid(txn_valid),
    .txn_addr(txn_addr), .pref_hit_valid(pref_hit_valid), .pref_hit(pref_hit),
    .io_start_high(io_start_high), .io_end_high(io_end_high)
  );

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    mismatches++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Ready is looked at just before the edge that samples it
  task automatic wait_ready(output logic [31:0] data);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (hreadyout !== 1'b1 && n < 50) begin
      n++;
      @(negedge sys_clk);
    end
    if (n >= 50) begin
      mismatches++;
    end
    data = hrdata;
    @(posedge sys_clk);
  endtask

  task automatic ahb(input logic [9:0] idx, input logic wr, input logic [2:0] sz,
                     input logic [31:0] wd, output logic [31:0] rd);
    logic [31:0] unused;
    hsel <= 1'b1;
    haddr <= {20'h00000, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= sz;
    wait_ready(unused);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_ready(rd);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    logic [31:0] rd;
    ahb(idx, 1'b1, bwcfg_pkg::HSIZE_WORD, d, rd);
  endtask

  task automatic rc(input string name, input logic [9:0] idx, input logic [31:0] e);
    logic [31:0] rd;
    ahb(idx, 1'b0, bwcfg_pkg::HSIZE_WORD, 32'h00000000, rd);
    chk(name, {32'h00000000, rd}, {32'h00000000, e});
    chk("hresp", {63'h0, hresp}, 64'h0);
  endtask

  // Lookup answer stands for one cycle, one edge after the request
  task automatic lk(input logic [63:0] a, input logic e);
    txn_valid <= 1'b1;
    txn_addr <= a;
    @(posedge sys_clk);
    txn_valid <= 1'b0;
    @(negedge sys_clk);
    chk("pref_hit_valid", {63'h0, pref_hit_valid}, 64'h1);
    chk("pref_hit", {63'h0, pref_hit}, {63'h0, e});
    @(posedge sys_clk);
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    mismatches = 0;
    n_checks = 0;
    srst <= 1'b1;
    hsel <= 1'b0;
    haddr <= 32'h00000000;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hsize <= bwcfg_pkg::HSIZE_WORD;
    hwdata <= 32'h00000000;
    io_width_capability <= 1'b1;
    txn_valid <= 1'b0;
    txn_addr <= 64'h0;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;

    rc("start", bwcfg_pkg::IDX_START, 32'h0000fff1);
    rc("end", bwcfg_pkg::IDX_END, 32'h00000001);
    rc("start_high", bwcfg_pkg::IDX_START_HIGH, 32'hffffffff);
    rc("end_high", bwcfg_pkg::IDX_END_HIGH, 32'h00000000);
    rc("io_start_high", bwcfg_pkg::IDX_IO_START_HIGH, 32'h0000ffff);
    rc("io_end_high", bwcfg_pkg::IDX_IO_END_HIGH, 32'h00000000);
    rc("cap_head", bwcfg_pkg::IDX_CAP_HEAD, 32'h00000040);
    rc("option_rom", bwcfg_pkg::IDX_OPTION_ROM, 32'h00000000);
    rc("irq_routing", bwcfg_pkg::IDX_IRQ_ROUTING, 32'h00000000);
    rc("write_lock", bwcfg_pkg::IDX_WRITE_LOCK, 32'h00000000);
    rc("status", bwcfg_pkg::IDX_STATUS, 32'h00000006);
    chk("io_start_high port", {48'h0, io_start_high}, 64'hffff);
    $display("test reset_values done");

    // Locked fields and read-only places refuse writes
    wr(bwcfg_pkg::IDX_START, 32'hffff123e);
    rc("start", bwcfg_pkg::IDX_START, 32'h00001231);
    wr(bwcfg_pkg::IDX_END, 32'h0000abce);
    rc("end", bwcfg_pkg::IDX_END, 32'h0000abc1);
    wr(bwcfg_pkg::IDX_CAP_HEAD, 32'h00000080);
    rc("cap_head", bwcfg_pkg::IDX_CAP_HEAD, 32'h00000040);
    wr(bwcfg_pkg::IDX_OPTION_ROM, 32'hffffffff);
    rc("option_rom", bwcfg_pkg::IDX_OPTION_ROM, 32'h00000000);
    wr(bwcfg_pkg::IDX_IRQ_ROUTING, 32'h000000a5);
    rc("irq_routing", bwcfg_pkg::IDX_IRQ_ROUTING, 32'h000000a5);
    wr(10'h200, 32'hdeadbeef);
    rc("unmapped", 10'h200, 32'h00000000);
    $display("test refused_writes done");

    // I/O high halves vanish while the I/O width bit is clear
    wr(bwcfg_pkg::IDX_IO_END_HIGH, 32'h00005678);
    io_width_capability <= 1'b0;
    wr(bwcfg_pkg::IDX_IO_START_HIGH, 32'h00001234);
    rc("io_start_high", bwcfg_pkg::IDX_IO_START_HIGH, 32'h00000000);
    rc("io_end_high", bwcfg_pkg::IDX_IO_END_HIGH, 32'h00000000);
    chk("io_end_high port", {48'h0, io_end_high}, 64'h0);
    io_width_capability <= 1'b1;
    rc("io_start_high", bwcfg_pkg::IDX_IO_START_HIGH, 32'h0000ffff);
    rc("io_end_high", bwcfg_pkg::IDX_IO_END_HIGH, 32'h00005678);
    chk("io_end_high port", {48'h0, io_end_high}, 64'h5678);
    $display("test io_high done");

    // Lock open: capability bit and list head take writes
    wr(bwcfg_pkg::IDX_WRITE_LOCK, 32'h00000001);
    rc("write_lock", bwcfg_pkg::IDX_WRITE_LOCK, 32'h00000001);
    wr(bwcfg_pkg::IDX_CAP_HEAD, 32'h00000080);
    rc("cap_head", bwcfg_pkg::IDX_CAP_HEAD, 32'h00000080);
    wr(bwcfg_pkg::IDX_START_HIGH, 32'h00000001);
    wr(bwcfg_pkg::IDX_END_HIGH, 32'h00000001);
    wr(bwcfg_pkg::IDX_START, 32'h00000100);
    rc("start", bwcfg_pkg::IDX_START, 32'h00000100);
    rc("end", bwcfg_pkg::IDX_END, 32'h0000abc0);
    wr(bwcfg_pkg::IDX_END_HIGH, 32'h00000007);
    rc("start_high", bwcfg_pkg::IDX_START_HIGH, 32'h00000000);
    rc("end_high", bwcfg_pkg::IDX_END_HIGH, 32'h00000000);
    wr(bwcfg_pkg::IDX_START, 32'h00000101);
    rc("end_high", bwcfg_pkg::IDX_END_HIGH, 32'h00000001);
    $display("test lock_and_width done");

    // Window edges: base 0x1_0100_0000, limit 0x1_020f_ffff
    wr(bwcfg_pkg::IDX_END, 32'h00000200);
    // Status is read-only, so this write must leave everything alone
    wr(bwcfg_pkg::IDX_STATUS, 32'h00000000);
    rc("end", bwcfg_pkg::IDX_END, 32'h00000201);
    lk(64'h00000001_00ffffff, 1'b0);
    lk(64'h00000001_01000000, 1'b1);
    lk(64'h00000001_020fffff, 1'b1);
    lk(64'h00000001_02100000, 1'b0);
    lk(64'h00000002_01000000, 1'b0);
    wr(bwcfg_pkg::IDX_START, 32'h00000100);
    lk(64'h00000000_01000000, 1'b1);
    rc("status", bwcfg_pkg::IDX_STATUS, 32'h00000005);
    lk(64'h00000001_01000000, 1'b0);
    $display("test window done");
    end_of_test();
  end
endmodule

`default_nettype wire
